// ---- dv/fwd_core_model.sv ----
// Partner: behavioural processor core giving fetches, sleep and timer resets
`timescale 1ns/100ps
module fwd_core_model (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// Scenario controls
	input wire logic run_in,
	input wire logic nap_in,
	input wire logic leak_in,
	input wire logic rst_req_in,
	// Core signals
	output logic fetch_out,
	output logic sleep_out,
	output logic rst_ev_out
);
	// Leak lets a scenario push fetch strobes during sleep to probe the gate
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			fetch_out <= 1'b0;
			sleep_out <= 1'b0;
			rst_ev_out <= 1'b0;
		end else begin
			fetch_out <= run_in && (!nap_in || leak_in);
			sleep_out <= nap_in;
			rst_ev_out <= rst_req_in;
		end
	end
endmodule

// ---- dv/fwd_fetch_watchdog_test.sv ----
// Testbench: self-checking run of the fetch watchdog with its core model
`timescale 1ns/100ps
module fwd_fetch_watchdog_test;
	logic clk, rst, wr, rd, run, nap, leak, rq, fetch, slp, rev, ev, on, win, bail;
	logic [3:0] addr;
	logic [15:0] wd, rdata, m;
	logic [31:0] lf;
	logic [7:0] k;
	fwd_pkg::fwd_fuse_type fz;
	int fails, n_compared, n;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	fwd_fetch_watchdog fwd_fetch_watchdog_i (.core_clk_in(clk), .sys_rst_in(rst),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .fetch_in(fetch), .sleep_in(slp), .timer_reset_event_in(rev),
		.fuse_in(fz), .timer_event_out(ev), .timer_running_out(on),
		.clear_window_open_out(win));
	fwd_core_model fwd_core_model_i (.core_clk_in(clk), .sys_rst_in(rst), .run_in(run),
		.nap_in(nap), .leak_in(leak), .rst_req_in(rq), .fetch_out(fetch), .sleep_out(slp),
		.rst_ev_out(rev));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] nx(input logic [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] st(input logic bp, bc, e, w);
		st = {8'h00, bp, bc, e, 4'h0, w};
	endfunction
	function automatic logic [15:0] rv(input logic [3:0] a);
		case (a)
			fwd_pkg::ADDR_MATCH_MIRROR_LOW: rv = fz.match_low;
			fwd_pkg::ADDR_MATCH_MIRROR_HIGH: rv = fz.match_high;
			fwd_pkg::ADDR_WINDOW_MIRROR_LOW: rv = fz.window_low;
			fwd_pkg::ADDR_WINDOW_MIRROR_HIGH: rv = fz.window_high;
			default: rv = 16'h0000;
		endcase
	endfunction
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data stands only in the beat after the strobe, so it is sampled there
	task rreg(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task go(input int c);
		@(posedge clk);
		run <= 1'b1;
		repeat (c) @(posedge clk);
		run <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task pulse;
		@(posedge clk);
		rq <= 1'b1;
		@(posedge clk);
		rq <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// Fuses change only inside reset; mirrors load them while reset is still held
	task boot(input fwd_pkg::fwd_fuse_type f);
		@(posedge clk);
		rst <= 1'b1;
		fz <= f;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task regs;
		logic [3:0] a;
		for (int j = 0; j < 12; j++) begin
			a = (j == 11) ? 4'hf : 4'(j);
			rreg(a, rv(a));
		end
	endtask
	initial begin
		for (int j = 0; j < 20000 && !bail; j++) @(posedge clk);
		fails++;
		final_report;
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst, wr, rd, run, nap, leak, rq, bail} = 8'h80;
		addr = 4'h0;
		wd = 16'h0000;
		fz = '0;
		fails = 0;
		n_compared = 0;
		lf = nx(32'hadcf);
		m = 16'h0014 + {12'h000, lf[3:0]};
		boot({16'h0000, m, 32'h0000_0000, 2'b00});
		regs;
		chk({15'h0000, on}, 16'h0000);
		wreg(fwd_pkg::ADDR_STATUS, 16'hffff);
		wreg(fwd_pkg::ADDR_COUNT_LOW, 16'h1234);
		rreg(fwd_pkg::ADDR_STATUS, 16'h0000);
		$display("test reset values done");
		wreg(fwd_pkg::ADDR_CONTROL, 16'hffff);
		rreg(fwd_pkg::ADDR_CONTROL, 16'h8000);
		chk({15'h0000, on}, 16'h0001);
		lf = nx(lf);
		n = 1 + lf[3:0];
		go(n);
		rreg(fwd_pkg::ADDR_COUNT_LOW, 16'(n));
		rreg(fwd_pkg::ADDR_HOLD, 16'h0000);
		@(posedge clk);
		nap <= 1'b1;
		leak <= 1'b1;
		go(5);
		nap <= 1'b0;
		leak <= 1'b0;
		rreg(fwd_pkg::ADDR_COUNT_LOW, 16'(n));
		rreg(fwd_pkg::ADDR_STATUS, st(0, 0, 0, 1));
		chk({15'h0000, win}, 16'h0001);
		$display("test counting done");
		wreg(fwd_pkg::ADDR_PRECLEAR, 16'h40ff);
		rreg(fwd_pkg::ADDR_PRECLEAR, 16'h4000);
		wreg(fwd_pkg::ADDR_CLEAR, {8'h00, fwd_pkg::CLEAR_KEY_VALUE});
		rreg(fwd_pkg::ADDR_COUNT_LOW, 16'h0000);
		rreg(fwd_pkg::ADDR_PRECLEAR, 16'h0000);
		rreg(fwd_pkg::ADDR_CLEAR, 16'h0000);
		rreg(fwd_pkg::ADDR_STATUS, st(0, 0, 0, 1));
		$display("test clear done");
		lf = nx(lf);
		k = (lf[15:8] == fwd_pkg::PRECLEAR_KEY_VALUE) ? ~lf[15:8] : lf[15:8];
		wreg(fwd_pkg::ADDR_PRECLEAR, {k, 8'h00});
		rreg(fwd_pkg::ADDR_STATUS, st(1, 0, 1, 1));
		rreg(fwd_pkg::ADDR_PRECLEAR, {k, 8'h00});
		pulse;
		rreg(fwd_pkg::ADDR_STATUS, st(0, 0, 0, 1));
		rreg(fwd_pkg::ADDR_PRECLEAR, 16'h0000);
		wreg(fwd_pkg::ADDR_PRECLEAR, {fwd_pkg::PRECLEAR_KEY_VALUE, 8'h00});
		k = (lf[23:16] == fwd_pkg::CLEAR_KEY_VALUE) ? ~lf[23:16] : lf[23:16];
		wreg(fwd_pkg::ADDR_CLEAR, {8'h00, k});
		rreg(fwd_pkg::ADDR_STATUS, st(0, 1, 1, 1));
		rreg(fwd_pkg::ADDR_PRECLEAR, 16'h4000);
		rreg(fwd_pkg::ADDR_CLEAR, {8'h00, k});
		pulse;
		rreg(fwd_pkg::ADDR_CLEAR, 16'h0000);
		wreg(fwd_pkg::ADDR_CLEAR, {8'h00, fwd_pkg::CLEAR_KEY_VALUE});
		rreg(fwd_pkg::ADDR_STATUS, st(0, 1, 1, 1));
		pulse;
		$display("test bad keys done");
		@(posedge clk);
		run <= 1'b1;
		for (int j = 0; j < 100 && ev !== 1'b1; j++) begin
			@(posedge clk);
			#1;
		end
		chk({15'h0000, ev}, 16'h0001);
		bail = (ev !== 1'b1);
		@(posedge clk);
		run <= 1'b0;
		#1;
		chk({15'h0000, ev}, 16'h0000);
		chk({15'h0000, on}, 16'h0000);
		repeat (4) @(posedge clk);
		rreg(fwd_pkg::ADDR_COUNT_LOW, m);
		rreg(fwd_pkg::ADDR_COUNT_HIGH, 16'h0000);
		rreg(fwd_pkg::ADDR_STATUS, st(0, 0, 1, 0));
		pulse;
		rreg(fwd_pkg::ADDR_COUNT_LOW, 16'h0000);
		$display("test expiry done");
		lf = nx(lf);
		boot({lf[15:0], lf[31:16], lf[15:0] | 16'h0001, 16'h0005, 2'b11});
		regs;
		chk({15'h0000, on}, 16'h0001);
		wreg(fwd_pkg::ADDR_PRECLEAR, {fwd_pkg::PRECLEAR_KEY_VALUE, 8'h00});
		wreg(fwd_pkg::ADDR_CLEAR, {8'h00, fwd_pkg::CLEAR_KEY_VALUE});
		rreg(fwd_pkg::ADDR_STATUS, st(0, 1, 1, 0));
		boot({lf[15:0], lf[31:16], 32'h0000_0000, 2'b10});
		wreg(fwd_pkg::ADDR_CONTROL, 16'h8000);
		go(3);
		chk({15'h0000, on}, 16'h0000);
		rreg(fwd_pkg::ADDR_COUNT_LOW, 16'h0000);
		$display("test fuse control done");
		final_report;
	end
endmodule

// ---- dv/fwd_properties.sv ----
// Checker: port-level properties of the fetch watchdog
`timescale 1ns/100ps
module fwd_properties (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	// Fuses and status
	input wire fwd_pkg::fwd_fuse_type fuse_in,
	input wire logic timer_event_out,
	input wire logic timer_running_out
);
	logic rd_r;
	logic [3:0] addr_r;
	logic pre_w;
	logic clr_w;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Read beat tracking, cleared in reset so idle data is judged at once
	always_ff @(posedge core_clk_in) begin
		rd_r <= reg_rd_in && !sys_rst_in;
		addr_r <= reg_addr_in;
	end
	assign pre_w = reg_wr_in && reg_addr_in == fwd_pkg::ADDR_PRECLEAR;
	assign clr_w = reg_wr_in && reg_addr_in == fwd_pkg::ADDR_CLEAR;
	a_rdata_idle: assert property (!rd_r |-> reg_rdata_out == 16'h0000)
		else $error("read data outside read beat");
	a_ctrl_zero: assert property (rd_r && addr_r == fwd_pkg::ADDR_CONTROL
		|-> reg_rdata_out[14:0] == 15'h0000) else $error("control spare bits");
	a_pre_zero: assert property (rd_r && addr_r == fwd_pkg::ADDR_PRECLEAR
		|-> reg_rdata_out[7:0] == 8'h00) else $error("preclear spare bits");
	a_clr_zero: assert property (rd_r && addr_r == fwd_pkg::ADDR_CLEAR
		|-> reg_rdata_out[15:8] == 8'h00) else $error("clear spare bits");
	a_stat_zero: assert property (rd_r && addr_r == fwd_pkg::ADDR_STATUS
		|-> {reg_rdata_out[15:8], reg_rdata_out[4:1]} == 12'h000)
		else $error("status spare bits");
	a_match_mirror: assert property (rd_r && addr_r == fwd_pkg::ADDR_MATCH_MIRROR_LOW
		|-> reg_rdata_out == fuse_in.match_low) else $error("match mirror");
	a_window_mirror: assert property (rd_r && addr_r == fwd_pkg::ADDR_WINDOW_MIRROR_HIGH
		|-> reg_rdata_out == fuse_in.window_high) else $error("window mirror");
	a_bad_pre_event: assert property (pre_w && reg_wdata_in[15:8] != fwd_pkg::PRECLEAR_KEY_VALUE
		|-> ##[1:2] timer_event_out) else $error("no event on bad preclear");
	a_bad_clr_event: assert property (clr_w && reg_wdata_in[7:0] != fwd_pkg::CLEAR_KEY_VALUE
		|-> ##[1:2] timer_event_out) else $error("no event on bad clear");
	a_fuse_off: assert property (fuse_in.fuse_disable && !fuse_in.fuse_run
		|-> !timer_running_out) else $error("running while fuse off");
	c_event: cover property ($rose(timer_event_out));
	c_run: cover property ($rose(timer_running_out));
	c_clear: cover property (clr_w ##1 !timer_event_out);
endmodule
bind fwd_fetch_watchdog fwd_properties fwd_properties_i (.core_clk_in, .sys_rst_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .fuse_in,
	.timer_event_out, .timer_running_out);

// ---- src/fwd_fetch_watchdog.sv ----
// Module: instruction fetch watchdog with two-step key clear and register port
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps

// Overview of operation
// R1: Counter runs on system clock, one step per fetch, until it equals match.
// R2: No counting while the processor sleeps.
// R3: 32-bit counter; match value built from two 16-bit fuse words.
// R4: Enabled by fuse setting or by software enable at control bit 15.
// R5: Software enable counts only when fuse disable is 0; else fuse decides.
// R6: Software writes 0x40 to preclear field bits 15-8; device records valid preclear.
// R7: Any other preclear value sets the bad-preclear flag.
// R8: Preclear field clears on timer reset event or on correct clear key.
// R9: Correct clear key after valid preclear clears both fields and the counter.
// R10: Counter clear is visible at once through the count registers.
// R11: Wrong clear key sets bad-clear, keeps preclear field, stores written value.
// R12: Clear key field clears on every timer reset event; a bad clear written in that same cycle is stored instead.
// R13: Status bits 7, 6, 5 give bad-preclear, bad-clear, event; hardware cleared.
// R14: Event flag sets on expiry or on any bad key write.
// R15: Status bit 0 shows the clear window open.
// R16: Count readable as live low and high 16-bit halves.
// R17: Match mirror low register always returns the low match fuse word.
// R18: Count match signals the processor with an event.
// R19: Unimplemented bits of control, key and status registers read zero.
// R20: Hold register loads upper count half only on count reads; resets to zero.
// R21: Window mirror registers always return the two window fuse words.
// R22: Clear pattern is one fixed 8-bit constant differing from preclear.
// R23: Clear accepted only while window open; otherwise treated as bad clear.
module fwd_fetch_watchdog (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// Processor core
	input wire logic fetch_in,
	input wire logic sleep_in,
	input wire logic timer_reset_event_in,
	// Configuration fuses
	input wire fwd_pkg::fwd_fuse_type fuse_in,
	// Status to the core
	output logic timer_event_out,
	output logic timer_running_out,
	output logic clear_window_open_out
);

	// ****************************************
	// Declarations
	// ****************************************
	logic on_r;
	logic [7:0] preclear_key_r;
	logic [7:0] clear_key_r;
	logic bad_preclear_flag_r;
	logic bad_clear_flag_r;
	logic timer_event_flag_r;
	logic [31:0] count_r;
	logic [31:0] count_nxt;
	logic [15:0] held_upper_count_r;
	fwd_pkg::fwd_seq_type seq_r;
	fwd_pkg::fwd_seq_type seq_nxt;
	logic [15:0] match_mirror_low;
	logic [15:0] match_mirror_high;
	logic [15:0] window_mirror_low;
	logic [15:0] window_mirror_high;
	logic [31:0] match_value;
	logic [31:0] window_value;
	logic enabled;
	logic wr_control;
	logic wr_preclear;
	logic wr_clear;
	logic rd_count;
	logic good_preclear;
	logic bad_preclear;
	logic good_clear;
	logic bad_clear;
	logic count_step;
	logic expire;
	logic window_open;
	logic [15:0] rdata_nxt;

	// ****************************************
	// Fuse mirrors
	// ****************************************
	fwd_fuse_mirror #(
		.WIDTH(16)
	) u_match_low (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.fuse_word_in(fuse_in.match_low),
		.mirror_out(match_mirror_low)
	);

	fwd_fuse_mirror #(
		.WIDTH(16)
	) u_match_high (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.fuse_word_in(fuse_in.match_high),
		.mirror_out(match_mirror_high)
	);

	fwd_fuse_mirror #(
		.WIDTH(16)
	) u_window_low (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.fuse_word_in(fuse_in.window_low),
		.mirror_out(window_mirror_low)
	);

	fwd_fuse_mirror #(
		.WIDTH(16)
	) u_window_high (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.fuse_word_in(fuse_in.window_high),
		.mirror_out(window_mirror_high)
	);

	// ****************************************
	// Decode and enable
	// ****************************************
	// Match and window compare against the mirrors so both see one stable copy
	assign match_value = {match_mirror_high, match_mirror_low}; // [R3]
	assign window_value = {window_mirror_high, window_mirror_low};

	// Software bit matters only while the fuse leaves control to software
	assign enabled = fuse_in.fuse_disable ? fuse_in.fuse_run : on_r; // [R4] [R5]

	assign wr_control = reg_wr_in && (reg_addr_in == fwd_pkg::ADDR_CONTROL);
	assign wr_preclear = reg_wr_in && (reg_addr_in == fwd_pkg::ADDR_PRECLEAR);
	assign wr_clear = reg_wr_in && (reg_addr_in == fwd_pkg::ADDR_CLEAR);
	assign rd_count = reg_rd_in && ((reg_addr_in == fwd_pkg::ADDR_COUNT_LOW) ||
		(reg_addr_in == fwd_pkg::ADDR_COUNT_HIGH));

	// ****************************************
	// Key checks
	// ****************************************
	assign good_preclear = wr_preclear &&
		(reg_wdata_in[15:8] == fwd_pkg::PRECLEAR_KEY_VALUE); // [R6]
	assign bad_preclear = wr_preclear && !good_preclear; // [R7]

	// Clear needs the armed step, the right pattern and an open window
	assign good_clear = wr_clear && (seq_r == fwd_pkg::SEQ_ARMED) &&
		(reg_wdata_in[7:0] == fwd_pkg::CLEAR_KEY_VALUE) && window_open; // [R9] [R22] [R23]
	assign bad_clear = wr_clear && !good_clear; // [R11] [R23]

	// ****************************************
	// Counter
	// ****************************************
	assign count_step = enabled && fetch_in && !sleep_in &&
		(seq_r != fwd_pkg::SEQ_EXPIRED); // [R1] [R2]
	assign expire = enabled && (seq_r != fwd_pkg::SEQ_EXPIRED) &&
		(count_r == match_value); // [R1] [R18]
	assign window_open = enabled && (seq_r != fwd_pkg::SEQ_EXPIRED) &&
		(count_r >= window_value);

	always_comb begin
		count_nxt = count_r;
		if (timer_reset_event_in || good_clear) begin
			count_nxt = fwd_pkg::COUNT_RESET; // [R9]
		end else if (count_step && !expire) begin
			count_nxt = count_r + 32'h0000_0001; // [R1]
		end
	end

	// Count reads take the register directly, so a clear is seen next cycle
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			count_r <= fwd_pkg::COUNT_RESET;
		end else begin
			count_r <= count_nxt; // [R10]
		end
	end

	// ****************************************
	// Clear sequence
	// ****************************************
	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			fwd_pkg::SEQ_IDLE: begin
				if (expire) begin
					seq_nxt = fwd_pkg::SEQ_EXPIRED;
				end else if (good_preclear) begin
					seq_nxt = fwd_pkg::SEQ_ARMED;
				end
			end
			fwd_pkg::SEQ_ARMED: begin
				if (expire) begin
					seq_nxt = fwd_pkg::SEQ_EXPIRED;
				end else if (good_clear || bad_preclear) begin
					seq_nxt = fwd_pkg::SEQ_IDLE;
				end
			end
			fwd_pkg::SEQ_EXPIRED: begin
				seq_nxt = fwd_pkg::SEQ_EXPIRED;
			end
			default: begin
				seq_nxt = fwd_pkg::SEQ_IDLE;
			end
		endcase
		if (timer_reset_event_in) begin
			seq_nxt = fwd_pkg::SEQ_IDLE;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			seq_r <= fwd_pkg::SEQ_IDLE;
		end else begin
			seq_r <= seq_nxt;
		end
	end

	// ****************************************
	// Control register
	// ****************************************
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			on_r <= 1'b0;
		end else if (wr_control) begin
			on_r <= reg_wdata_in[fwd_pkg::CTRL_ON_BIT]; // [R4]
		end
	end

	// ****************************************
	// Key fields
	// ****************************************
	// A key write in the same cycle as a reset event wins over the event
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			preclear_key_r <= fwd_pkg::KEY_RESET;
		end else if (wr_preclear) begin
			preclear_key_r <= reg_wdata_in[15:8]; // [R6]
		end else if (good_clear || timer_reset_event_in) begin
			preclear_key_r <= fwd_pkg::KEY_RESET; // [R8]
		end
	end

	// Bad clear keeps the preclear field: the branch above is not taken
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			clear_key_r <= fwd_pkg::KEY_RESET;
		end else if (good_clear) begin
			clear_key_r <= fwd_pkg::KEY_RESET; // [R9]
		end else if (bad_clear) begin
			clear_key_r <= reg_wdata_in[7:0]; // [R11]
		end else if (timer_reset_event_in) begin
			clear_key_r <= fwd_pkg::KEY_RESET; // [R12]
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	// Only the reset event clears them, and a new fault in that cycle wins
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			bad_preclear_flag_r <= 1'b0;
		end else if (bad_preclear) begin
			bad_preclear_flag_r <= 1'b1; // [R7]
		end else if (timer_reset_event_in) begin
			bad_preclear_flag_r <= 1'b0; // [R13]
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			bad_clear_flag_r <= 1'b0;
		end else if (bad_clear) begin
			bad_clear_flag_r <= 1'b1; // [R11]
		end else if (timer_reset_event_in) begin
			bad_clear_flag_r <= 1'b0; // [R13]
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			timer_event_flag_r <= 1'b0;
		end else if (expire || bad_preclear || bad_clear) begin
			timer_event_flag_r <= 1'b1; // [R14]
		end else if (timer_reset_event_in) begin
			timer_event_flag_r <= 1'b0; // [R13]
		end
	end

	// ****************************************
	// Outputs to the core
	// ****************************************
	// One pulse per fault; expiry fires once because the state then leaves counting
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			timer_event_out <= 1'b0;
			timer_running_out <= 1'b0;
			clear_window_open_out <= 1'b0;
		end else begin
			timer_event_out <= expire || bad_preclear || bad_clear; // [R14] [R18]
			timer_running_out <= enabled && (seq_nxt != fwd_pkg::SEQ_EXPIRED);
			clear_window_open_out <= window_open; // [R15]
		end
	end

	// ****************************************
	// Hold register
	// ****************************************
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			held_upper_count_r <= fwd_pkg::REG_RESET;
		end else if (rd_count) begin
			held_upper_count_r <= count_r[31:16]; // [R20]
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		rdata_nxt = fwd_pkg::REG_RESET;
		case (reg_addr_in)
			fwd_pkg::ADDR_CONTROL: begin
				rdata_nxt[fwd_pkg::CTRL_ON_BIT] = on_r; // [R19]
			end
			fwd_pkg::ADDR_PRECLEAR: begin
				rdata_nxt[15:8] = preclear_key_r; // [R19]
			end
			fwd_pkg::ADDR_CLEAR: begin
				rdata_nxt[7:0] = clear_key_r; // [R19]
			end
			fwd_pkg::ADDR_STATUS: begin
				rdata_nxt[fwd_pkg::STAT_BAD_PRECLEAR_BIT] = bad_preclear_flag_r; // [R13]
				rdata_nxt[fwd_pkg::STAT_BAD_CLEAR_BIT] = bad_clear_flag_r; // [R13]
				rdata_nxt[fwd_pkg::STAT_EVENT_BIT] = timer_event_flag_r; // [R13]
				rdata_nxt[fwd_pkg::STAT_WINDOW_BIT] = window_open; // [R15]
			end
			fwd_pkg::ADDR_COUNT_LOW: begin
				rdata_nxt = count_r[15:0]; // [R16]
			end
			fwd_pkg::ADDR_COUNT_HIGH: begin
				rdata_nxt = count_r[31:16]; // [R16]
			end
			fwd_pkg::ADDR_MATCH_MIRROR_LOW: begin
				rdata_nxt = match_mirror_low; // [R17]
			end
			fwd_pkg::ADDR_MATCH_MIRROR_HIGH: begin
				rdata_nxt = match_mirror_high;
			end
			fwd_pkg::ADDR_WINDOW_MIRROR_LOW: begin
				rdata_nxt = window_mirror_low; // [R21]
			end
			fwd_pkg::ADDR_WINDOW_MIRROR_HIGH: begin
				rdata_nxt = window_mirror_high; // [R21]
			end
			fwd_pkg::ADDR_HOLD: begin
				rdata_nxt = held_upper_count_r; // [R20]
			end
			default: begin
				rdata_nxt = fwd_pkg::REG_RESET;
			end
		endcase
	end

	// Data stand only in the cycle after the read strobe, zero otherwise
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= fwd_pkg::REG_RESET;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_nxt;
		end else begin
			reg_rdata_out <= fwd_pkg::REG_RESET;
		end
	end

endmodule

// ---- src/fwd_fuse_mirror.sv ----
// Module: one clocked copy of a configuration fuse word
`timescale 1ns/100ps
module fwd_fuse_mirror #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// Fuse word
	input wire logic [WIDTH-1:0] fuse_word_in,
	output logic [WIDTH-1:0] mirror_out
);

	// ****************************************
	// Mirror
	// ****************************************
	// Fuse lines are static straps, so they load during reset as well.
	// A zero mirror right after release would match a zero count and
	// expire a fuse-enabled timer at once.
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			mirror_out <= fuse_word_in;
		end else begin
			mirror_out <= fuse_word_in;
		end
	end

endmodule

// ---- src/fwd_pkg.sv ----
// Package: register map, key patterns, field layout and fuse carrier of the fetch watchdog
package fwd_pkg;

	// ****************************************
	// Register indices on the register port
	// ****************************************
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_PRECLEAR = 4'h1;
	localparam logic [3:0] ADDR_CLEAR = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_COUNT_LOW = 4'h4;
	localparam logic [3:0] ADDR_COUNT_HIGH = 4'h5;
	localparam logic [3:0] ADDR_MATCH_MIRROR_LOW = 4'h6;
	localparam logic [3:0] ADDR_MATCH_MIRROR_HIGH = 4'h7;
	localparam logic [3:0] ADDR_WINDOW_MIRROR_LOW = 4'h8;
	localparam logic [3:0] ADDR_WINDOW_MIRROR_HIGH = 4'h9;
	localparam logic [3:0] ADDR_HOLD = 4'ha;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_ON_BIT = 15;
	localparam int STAT_BAD_PRECLEAR_BIT = 7;
	localparam int STAT_BAD_CLEAR_BIT = 6;
	localparam int STAT_EVENT_BIT = 5;
	localparam int STAT_WINDOW_BIT = 0;
	localparam int PRECLEAR_KEY_LSB = 8;
	localparam int CLEAR_KEY_LSB = 0;

	// ****************************************
	// Key patterns and reset values
	// ****************************************
	localparam logic [7:0] PRECLEAR_KEY_VALUE = 8'h40;
	// Clear pattern: arbitrary choice, only required to differ from the preclear one
	localparam logic [7:0] CLEAR_KEY_VALUE = 8'h08;
	localparam logic [7:0] KEY_RESET = 8'h00;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [15:0] match_high;
		logic [15:0] match_low;
		logic [15:0] window_high;
		logic [15:0] window_low;
		logic fuse_disable;
		logic fuse_run;
	} fwd_fuse_type;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ARMED = 2'b01,
		SEQ_EXPIRED = 2'b10
	} fwd_seq_type;

endpackage
